// ### logic/mode_config_top.sv
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "mode_config_defines.svh"
// ===========================================================
// Mode straps, host register port and configuration outputs
module mode_config_top (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Wishbone slave
	input  wire logic [9:0]   wb_adr_i,
	input  wire logic [31:0]  wb_dat_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic         wb_we_i,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	output logic [31:0]       wb_dat_o,
	output logic              wb_ack_o,
	// Straps
	input  wire logic         oversample_strap_hi_i,
	input  wire logic         oversample_strap_mid_i,
	input  wire logic         oversample_strap_lo_i,
	input  wire logic         interface_select_strap_i,
	input  wire logic         range_strap_i,
	// Host reset pin
	input  wire logic         host_reset_i,
	// Serial port
	input  wire logic         sclk_i,
	input  wire logic         cs_n_i,
	input  wire logic         sdi_i,
	output logic              sdo_o,
	output logic              sdo_oe_o,
	// Parallel port
	input  wire logic         par_cs_n_i,
	input  wire logic         par_wr_n_i,
	input  wire logic [15:0]  par_db_i,
	// Configuration outputs and interrupt
	output logic              sw_mode_o,
	output logic              serial_if_o,
	output logic [15:0]       span_sel_o,
	output logic [3:0]        oversample_factor_o,
	output logic [1:0]        dout_lines_o,
	output logic              irq_o
);
	// ===========================================================
	// Strap capture
	logic        load_reg, sw_mode_reg, sw_mode_next, serial_reg, serial_next;
	logic        pin_d_reg, par_wr_d_reg, host_reset_rise;
	logic [2:0]  hw_os_reg, hw_os_next;

	assign host_reset_rise = host_reset_i & ~pin_d_reg;

	// Straps are caught after reset release, never inside the reset branch
	always_comb
	begin
		sw_mode_next = sw_mode_reg;
		serial_next = serial_reg;
		hw_os_next = hw_os_reg;
		if (load_reg || host_reset_rise)
		begin
			sw_mode_next = oversample_strap_hi_i & oversample_strap_mid_i
				& oversample_strap_lo_i; // [R1]
			serial_next = interface_select_strap_i; // [R2]
			hw_os_next = {oversample_strap_hi_i, oversample_strap_mid_i,
				oversample_strap_lo_i};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			load_reg <= 1'b1;
			sw_mode_reg <= 1'b0;
			serial_reg <= 1'b0;
			hw_os_reg <= 3'h0;
			pin_d_reg <= 1'b0;
			par_wr_d_reg <= 1'b1;
		end
		else
		begin
			load_reg <= 1'b0;
			sw_mode_reg <= sw_mode_next;
			serial_reg <= serial_next;
			hw_os_reg <= hw_os_next;
			pin_d_reg <= host_reset_i;
			par_wr_d_reg <= par_wr_n_i;
		end
	end

	// ===========================================================
	// Host port: serial frames or parallel strobe
	host_req_if spi_bus ();
	logic       par_write, host_we, host_rd, wb_take, wb_write;
	logic [3:0] host_idx;
	logic [7:0] host_wdata, wb_idx;

	spi_frame u_spi (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.sclk_i   (sclk_i),
		.cs_n_i   (cs_n_i | ~serial_reg),
		.sdi_i    (sdi_i),
		.sdo_o    (sdo_o),
		.sdo_oe_o (sdo_oe_o),
		.req      (spi_bus.src)
	);

	logic       reg_mode_reg, reg_mode_next, detect_reg, detect_next;
	logic [7:0] cfg_reg [0:15];
	logic [7:0] cfg_next [0:15];

	assign par_write = ~serial_reg & ~par_cs_n_i & par_wr_d_reg & ~par_wr_n_i; // [R9]
	assign host_idx = serial_reg ? spi_bus.addr[3:0] : par_db_i[11:8];
	assign host_wdata = serial_reg ? spi_bus.wdata : par_db_i[7:0];
	// Serial writes before the first serial read are dropped; parallel writes are not
	assign host_we = sw_mode_reg & ((serial_reg & spi_bus.valid & ~spi_bus.rd
		& reg_mode_reg) | par_write); // [R14]
	assign host_rd = sw_mode_reg & serial_reg & spi_bus.valid & spi_bus.rd;
	assign wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_write = wb_take & wb_we_i & wb_sel_i[0];
	assign wb_idx = wb_adr_i[9:2];

	function automatic logic writable(input logic [3:0] idx);
		writable = (idx == `REG_CONFIG) || (idx == `REG_OVERSAMPLE)
			|| (idx >= `REG_SPAN_FIRST && idx <= `REG_SPAN_LAST);
	endfunction

	function automatic logic [7:0] reg_default(input logic [3:0] idx);
		if (idx == `REG_CONFIG)
			reg_default = `CONFIG_DEFAULT;
		else if (idx >= `REG_SPAN_FIRST && idx <= `REG_SPAN_LAST)
			reg_default = `SPAN_DEFAULT;
		else
			reg_default = `OS_DEFAULT;
	endfunction

	function automatic logic [7:0] reg_read(input logic [3:0] idx);
		if (idx == `REG_STATUS)
			reg_read = {7'h00, detect_reg}; // [R7]
		else if (idx == `REG_IDENT)
			reg_read = {`PART_IDENTITY, `DIE_VERSION}; // [R7]
		else if (writable(idx))
			reg_read = cfg_reg[idx];
		else
			reg_read = 8'h00;
	endfunction

	assign spi_bus.rdata = (spi_bus.addr[6:4] == 3'h0) ? reg_read(spi_bus.addr[3:0]) : 8'h00;

	always_comb
	begin
		cfg_next = cfg_reg;
		reg_mode_next = reg_mode_reg;
		detect_next = detect_reg;
		if (host_reset_i)
		begin
			for (int i = 0; i < 16; i++)
				cfg_next[i] = reg_default(4'(i)); // [R6]
			reg_mode_next = 1'b0;
			detect_next = 1'b1;
		end
		else
		begin
			if (wb_write && wb_idx[7:4] == 4'h0 && writable(wb_idx[3:0]))
				cfg_next[wb_idx[3:0]] = wb_dat_i[7:0];
			// Host port wins a same-cycle clash with software
			if (host_we && writable(host_idx))
				cfg_next[host_idx] = host_wdata; // [R9]
			if (host_we && host_idx == `REG_STATUS && host_wdata[0])
				detect_next = 1'b0;
			if (host_rd)
				reg_mode_next = 1'b1; // [R14]
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 16; i++)
				cfg_reg[i] <= reg_default(4'(i)); // [R5]
			reg_mode_reg <= 1'b0;
			detect_reg <= 1'b1;
		end
		else
		begin
			cfg_reg <= cfg_next;
			reg_mode_reg <= reg_mode_next;
			detect_reg <= detect_next;
		end
	end

	// ===========================================================
	// Configuration outputs
	mode_config_pkg::span_e lane_span [0:7];
	logic [15:0] span_next;
	logic [3:0]  os_next, os_sw;
	logic [1:0]  lines_next;

	for (genvar g = 0; g < 8; g++)
	begin : g_lane
		span_lane u_lane (
			.sw_mode_i     (sw_mode_reg),
			.range_strap_i (range_strap_i),
			.code_i        (cfg_reg[`REG_SPAN_FIRST + g / 2][(g % 2) * 4 +: 4]), // [R15]
			.span_o        (lane_span[g])
		);
	end

	assign os_sw = cfg_reg[`REG_OVERSAMPLE][3:0];

	always_comb
	begin
		for (int i = 0; i < 8; i++)
			span_next[i * 2 +: 2] = lane_span[i];
		if (sw_mode_reg)
		begin
			os_next = (os_sw > `OS_SW_MAX) ? `OS_SW_MAX : os_sw; // [R10]
			lines_next = (cfg_reg[`REG_CONFIG][1:0] > `LINES_FOUR) ? `LINES_TWO
				: cfg_reg[`REG_CONFIG][1:0]; // [R12]
		end
		else
		begin
			os_next = {1'b0, hw_os_reg}; // [R11]
			lines_next = `LINES_TWO; // [R12]
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			span_sel_o <= 16'h0000;
			oversample_factor_o <= 4'h0;
			dout_lines_o <= `LINES_TWO;
		end
		else
		begin
			span_sel_o <= span_next;
			oversample_factor_o <= os_next;
			dout_lines_o <= lines_next;
		end
	end

	assign sw_mode_o = sw_mode_reg;
	assign serial_if_o = serial_reg;

	// ===========================================================
	// Interrupts and Wishbone slave
	logic [2:0]  irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next, events;
	logic [31:0] wb_dat_next;

	assign events = {host_rd, host_reset_rise, host_we};

	always_comb
	begin
		irq_stat_next = irq_stat_reg;
		irq_mask_next = irq_mask_reg;
		wb_dat_next = wb_dat_o;
		if (wb_take && !wb_we_i)
		begin
			if (wb_idx[7:4] == 4'h0)
				wb_dat_next = {24'h00_0000, reg_read(wb_idx[3:0])};
			else if (wb_idx == `WB_IRQ_STATUS)
			begin
				wb_dat_next = {29'h0000_0000, irq_stat_reg};
				irq_stat_next = 3'h0;
			end
			else if (wb_idx == `WB_IRQ_MASK)
				wb_dat_next = {29'h0000_0000, irq_mask_reg};
			else if (wb_idx == `WB_MODE_STATE)
				wb_dat_next = {23'h00_0000, reg_mode_reg, serial_reg, sw_mode_reg,
					dout_lines_o, oversample_factor_o};
			else
				wb_dat_next = 32'h0000_0000;
		end
		if (wb_write && wb_idx == `WB_IRQ_MASK)
			irq_mask_next = wb_dat_i[2:0];
		// New events win over the read clear
		irq_stat_next = irq_stat_next | events;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_stat_reg <= 3'h0;
			irq_mask_reg <= 3'h0;
			wb_dat_o <= 32'h0000_0000;
			wb_ack_o <= 1'b0;
		end
		else
		begin
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			wb_dat_o <= wb_dat_next;
			wb_ack_o <= wb_take;
		end
	end

	assign irq_o = |(irq_stat_reg & irq_mask_reg);

	// ===========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_sw_mode_straps: assert property ( // [R1]
		load_reg |=> sw_mode_reg == ($past(oversample_strap_hi_i)
			& $past(oversample_strap_mid_i) & $past(oversample_strap_lo_i)))
		else $error("software mode does not follow straps");
	a_iface_strap: assert property ( // [R2]
		load_reg |=> serial_reg == $past(interface_select_strap_i))
		else $error("interface select does not follow strap");
	a_sw_span_reg: assert property ( // [R3]
		sw_mode_reg && $stable(sw_mode_reg) && cfg_reg[3][3:0] == `SPAN_CODE_2P5
		|=> span_sel_o[1:0] == mode_config_pkg::SPAN_2P5)
		else $error("span not taken from register");
	a_upper_nibble: assert property ( // [R15]
		sw_mode_reg && $stable(sw_mode_reg) && cfg_reg[3][7:4] == `SPAN_CODE_5
		|=> span_sel_o[3:2] == mode_config_pkg::SPAN_5)
		else $error("upper channel span wrong");
	a_reset_reload: assert property ( // [R6]
		host_reset_rise |=> cfg_reg[`REG_SPAN_FIRST] == `SPAN_DEFAULT && detect_reg
			&& !reg_mode_reg)
		else $error("defaults not reloaded");
	a_os_hw_limit: assert property ( // [R11]
		!sw_mode_reg && $stable(sw_mode_reg) |=> oversample_factor_o <= `OS_HW_MAX)
		else $error("hardware oversample above 64");
	a_os_sw_limit: assert property ( // [R10]
		sw_mode_reg |=> oversample_factor_o <= `OS_SW_MAX)
		else $error("software oversample above 256");
	a_lines_hw_two: assert property ( // [R12]
		!sw_mode_reg |=> dout_lines_o == `LINES_TWO)
		else $error("hardware mode not two lines");
	a_write_gate: assert property ( // [R14]
		serial_reg && spi_bus.valid && !spi_bus.rd && !reg_mode_reg |-> !host_we)
		else $error("serial write before first read");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	c_sw_serial: cover property (sw_mode_reg && serial_reg && host_we);
	c_par_write: cover property (sw_mode_reg && par_write);
	c_host_reset: cover property (host_reset_rise ##1 irq_o);
endmodule

// ### logic/mode_config_defines.svh
`ifndef MODE_CONFIG_DEFINES_SVH
`define MODE_CONFIG_DEFINES_SVH
// How it works
// [R1] Software mode only when all three oversample straps are high
// [R2] Interface strap low selects parallel port, high selects serial port
// [R3] Software mode ignores the range strap; spans come from span registers
// [R4] Software mode spans are per channel, with 2.5 V beside 5 V and 10 V
// [R5] Entering software mode leaves every configuration register at its default
// [R6] Host pulses reset pin; device reloads all defaults
// [R7] Identity, version and reset-detect fields are readable by the host
// [R8] Serial port is an SPI slave in mode 2, polarity high, phase zero
// [R9] Registers written over serial data-in or over parallel write strobe
// [R10] Software mode oversample factor ranges from none up to 256
// [R11] Hardware mode oversample factor ranges from none up to 64
// [R12] Software mode selects one, two or four data lines; hardware fixes two
// [R13] Host writes span, oversample and other settings before using conversions
// [R14] A serial read must precede serial writes; it enables register access
// [R15] Span register holds two channels: high nibble upper, low nibble lower
// [R16] Serial frame is sixteen bits: flag, address, data; read answers next frame

// ===========================================================
// Host register indices
`define REG_STATUS       4'h1
`define REG_CONFIG       4'h2
`define REG_SPAN_FIRST   4'h3
`define REG_SPAN_LAST    4'h6
`define REG_OVERSAMPLE   4'h8
`define REG_IDENT        4'hA
// ===========================================================
// Wishbone word indices beyond the host map
`define WB_IRQ_STATUS    8'h10
`define WB_IRQ_MASK      8'h11
`define WB_MODE_STATE    8'h12
// ===========================================================
// Reset values and fields
`define CONFIG_DEFAULT   8'h01
`define SPAN_DEFAULT     8'h11
`define OS_DEFAULT       8'h00
// Identity values are arbitrary
`define PART_IDENTITY    4'h5
`define DIE_VERSION      4'h1
`define SPAN_CODE_2P5    4'h0
`define SPAN_CODE_5      4'h1
`define OS_SW_MAX        4'h8
`define OS_HW_MAX        4'h6
`define LINES_ONE        2'h0
`define LINES_TWO        2'h1
`define LINES_FOUR       2'h2
`define IRQ_HOST_WRITE   0
`define IRQ_HOST_RESET   1
`define IRQ_HOST_READ    2
`define FRAME_LAST_BIT   5'h0F
`endif

// ### logic/mode_config_pkg.sv
package mode_config_pkg;
	typedef enum logic [1:0] {SPAN_2P5, SPAN_5, SPAN_10} span_e;
	typedef logic [7:0] byte_t;
endpackage

// ### logic/host_req_if.sv
`timescale 1ns/10ps
// ===========================================================
// Serial frame handed from the SPI slave to the register file
interface host_req_if;
	logic                        valid;
	logic                        rd;
	logic [6:0]                  addr;
	mode_config_pkg::byte_t      wdata;
	mode_config_pkg::byte_t      rdata;
	modport src  (output valid, output rd, output addr, output wdata, input rdata);
	modport sink (input valid, input rd, input addr, input wdata, output rdata);
endinterface

// ### logic/span_lane.sv
`timescale 1ns/10ps
`include "mode_config_defines.svh"
// ===========================================================
// One channel's span choice
module span_lane (
	// Mode
	input  wire logic                   sw_mode_i,
	input  wire logic                   range_strap_i,
	// Span code nibble
	input  wire logic [3:0]             code_i,
	// Chosen span
	output mode_config_pkg::span_e      span_o
);
	always_comb
	begin
		if (!sw_mode_i) // [R3]
			span_o = range_strap_i ? mode_config_pkg::SPAN_10 : mode_config_pkg::SPAN_5;
		else if (code_i == `SPAN_CODE_2P5) // [R4]
			span_o = mode_config_pkg::SPAN_2P5;
		else if (code_i == `SPAN_CODE_5) // [R4]
			span_o = mode_config_pkg::SPAN_5;
		else
			span_o = mode_config_pkg::SPAN_10;
	end
endmodule

// ### logic/spi_frame.sv
`timescale 1ns/10ps
`include "mode_config_defines.svh"
// ===========================================================
// SPI slave, sixteen-bit frames
module spi_frame (
	// Clock and reset
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	// SPI pins
	input  wire logic  sclk_i,
	input  wire logic  cs_n_i,
	input  wire logic  sdi_i,
	output logic       sdo_o,
	output logic       sdo_oe_o,
	// Frame to register file
	host_req_if.src    req
);
	logic        sclk_d_reg, sclk_d_next, cs_d_reg, cs_d_next, valid_reg, valid_next;
	logic [15:0] in_reg, in_next, out_reg, out_next;
	logic [4:0]  cnt_reg, cnt_next;
	logic [7:0]  reply_reg, reply_next;
	logic        fall, rise, start;

	// Mode 2: idle high, sample on falling edge, shift out on rising edge
	assign fall = sclk_d_reg & ~sclk_i & ~cs_n_i; // [R8]
	assign rise = ~sclk_d_reg & sclk_i & ~cs_n_i; // [R8]
	assign start = cs_d_reg & ~cs_n_i;

	always_comb
	begin
		sclk_d_next = sclk_i;
		cs_d_next = cs_n_i;
		in_next = in_reg;
		out_next = out_reg;
		cnt_next = cnt_reg;
		valid_next = 1'b0;
		reply_next = valid_reg ? req.rdata : reply_reg; // [R16]
		if (start)
		begin
			cnt_next = 5'h00;
			out_next = {8'h00, reply_reg}; // [R16]
		end
		else if (fall)
		begin
			in_next = {in_reg[14:0], sdi_i};
			cnt_next = cnt_reg + 5'h01;
			valid_next = (cnt_reg == `FRAME_LAST_BIT); // [R16]
		end
		else if (rise)
			out_next = {out_reg[14:0], 1'b0};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sclk_d_reg <= 1'b1;
			cs_d_reg <= 1'b1;
			in_reg <= 16'h0000;
			out_reg <= 16'h0000;
			cnt_reg <= 5'h00;
			valid_reg <= 1'b0;
			reply_reg <= 8'h00;
		end
		else
		begin
			sclk_d_reg <= sclk_d_next;
			cs_d_reg <= cs_d_next;
			in_reg <= in_next;
			out_reg <= out_next;
			cnt_reg <= cnt_next;
			valid_reg <= valid_next;
			reply_reg <= reply_next;
		end
	end

	assign sdo_o = out_reg[15];
	assign sdo_oe_o = ~cs_n_i;
	assign req.valid = valid_reg;
	assign req.rd = in_reg[15];
	assign req.addr = in_reg[14:8];
	assign req.wdata = in_reg[7:0];

	// ===========================================================
	// Checks
	a_frame_sixteen: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		fall && cnt_reg == `FRAME_LAST_BIT |=> valid_reg)
		else $error("frame end not flagged");
	a_reply_loaded: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		start |=> out_reg == {8'h00, $past(reply_reg)})
		else $error("reply not loaded at frame start");
	c_frame_done: cover property (@(posedge clk_i) disable iff (rst_i) valid_reg);
endmodule

// ### testbench/host_spi_model.sv
`timescale 1ns/10ps
// ===========================================================
// Host SPI master, mode 2
module host_spi_model (
	// Clock
	input  wire logic  clk_i,
	// SPI pins
	output logic       sclk_o,
	output logic       cs_n_o,
	output logic       sdi_o,
	input  wire logic  sdo_i
);
	initial
	begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		sdi_o  = 1'b0;
	end

	// ===========================================================
	// Frame: data set while clock high, reply sampled on the fall
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			sdi_o <= tx[i];
			repeat (2) @(posedge clk_i);
			sclk_o <= 1'b0;
			rx = {rx[14:0], sdo_i};
			repeat (3) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (2) @(posedge clk_i);
		end
		cs_n_o <= 1'b1;
		// Idle line flips so a stale bit is never mistaken for data
		sdi_o  <= ~sdi_o;
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// ### testbench/tb.sv
`timescale 1ns/10ps
// ===========================================================
// Bench for straps, host ports and configuration outputs
module tb;
	typedef struct packed {logic [4:0] straps; logic sw; logic ser; logic [15:0] span;} row_s;
	// Straps: hi, mid, lo, interface select, range
	localparam row_s ROWS [5] = '{
		'{5'h1C, 1'b1, 1'b0, 16'h5555}, '{5'h1F, 1'b1, 1'b1, 16'h5555},
		'{5'h0D, 1'b0, 1'b0, 16'hAAAA}, '{5'h1A, 1'b0, 1'b1, 16'h5555},
		'{5'h01, 1'b0, 1'b0, 16'hAAAA}};
	localparam logic [7:0] RIDX [7] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h08, 8'h0A, 8'h20};
	localparam logic [7:0] RVAL [7] = '{8'h01, 8'h01, 8'h11, 8'h11, 8'h00, 8'h51, 8'h00};

	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic [9:0]   wb_adr_i = 10'h000;
	logic [31:0]  wb_dat_i = 32'h0000_0000;
	logic [3:0]   wb_sel_i = 4'h0;
	logic         wb_we_i = 1'b0;
	logic         wb_cyc_i = 1'b0;
	logic         wb_stb_i = 1'b0;
	logic [31:0]  wb_dat_o;
	logic         wb_ack_o;
	logic [4:0]   straps = 5'h1C;
	logic         host_reset_i = 1'b0;
	logic         sclk_i;
	logic         cs_n_i;
	logic         sdi_i;
	logic         sdo_o;
	logic         sdo_oe_o;
	logic         sdo_w;
	logic         par_cs_n_i = 1'b1;
	logic         par_wr_n_i = 1'b1;
	logic [15:0]  par_db_i = 16'h0000;
	logic         sw_mode_o;
	logic         serial_if_o;
	logic [15:0]  span_sel_o;
	logic [3:0]   oversample_factor_o;
	logic [1:0]   dout_lines_o;
	logic         irq_o;
	logic [31:0]  rd;
	logic [15:0]  rx;
	int           mismatches = 0;
	int           n_checks = 0;

	always #5 clk_i = ~clk_i;
	// Pull-up while the device leaves its data out released
	assign sdo_w = sdo_oe_o ? sdo_o : 1'b1;

	mode_config_top mode_config_top_inst (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
		.wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
		.oversample_strap_hi_i(straps[4]), .oversample_strap_mid_i(straps[3]),
		.oversample_strap_lo_i(straps[2]), .interface_select_strap_i(straps[1]),
		.range_strap_i(straps[0]), .host_reset_i, .sclk_i, .cs_n_i, .sdi_i, .sdo_o,
		.sdo_oe_o, .par_cs_n_i, .par_wr_n_i, .par_db_i, .sw_mode_o, .serial_if_o,
		.span_sel_o, .oversample_factor_o, .dout_lines_o, .irq_o);

	host_spi_model host_spi_model_inst (.clk_i(clk_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
		.sdi_o(sdi_i), .sdo_i(sdo_w));

	// ===========================================================
	// Shared tasks
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= {idx, 2'h0};
		wb_dat_i <= d;
		@(posedge clk_i iff wb_ack_o === 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask

	task par(input logic [3:0] idx, input logic [7:0] d);
		@(posedge clk_i);
		par_cs_n_i <= 1'b0;
		par_wr_n_i <= 1'b0;
		par_db_i   <= {4'h0, idx, d};
		@(posedge clk_i);
		par_cs_n_i <= 1'b1;
		par_wr_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask

	task hreset(input logic [4:0] s);
		@(posedge clk_i);
		straps       <= s;
		host_reset_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		host_reset_i <= 1'b0;
		repeat (5) @(posedge clk_i);
	endtask

	task spi(input logic [15:0] tx);
		host_spi_model_inst.xfer(tx, rx);
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ===========================================================
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < 7; i++)
		begin
			wb(1'b0, RIDX[i], 32'h0000_0000);
			chk("reset value", {24'h00_0000, RVAL[i]}, rd);
		end
		for (int i = 0; i < 5; i++)
		begin
			hreset(ROWS[i].straps);
			chk("sw_mode", ROWS[i].sw, sw_mode_o);
			chk("serial_if", ROWS[i].ser, serial_if_o);
			chk("span_sel", ROWS[i].span, span_sel_o);
			chk("dout_lines", 2'h1, dout_lines_o);
			if (!ROWS[i].sw)
				chk("hw factor cap", 1'b1, oversample_factor_o <= 4'h6);
		end
		// Hardware mode must drop a parallel write
		par(4'h3, 8'h20);
		chk("hw span kept", 16'hAAAA, span_sel_o);
		hreset(5'h1C);
		wb(1'b0, 8'h10, 32'h0000_0000);
		wb(1'b1, 8'h11, 32'h0000_0001);
		chk("irq idle", 1'b0, irq_o);
		par(4'h3, 8'h20);
		chk("span_sel", 16'h5558, span_sel_o);
		chk("irq raised", 1'b1, irq_o);
		wb(1'b0, 8'h03, 32'h0000_0000);
		chk("span reg", 32'h0000_0020, rd);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk("irq status", 1'b1, rd[0]);
		chk("irq cleared", 1'b0, irq_o);
		par(4'h8, 8'h07);
		chk("factor", 4'h7, oversample_factor_o);
		// Reset in mid-run
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("factor", 4'h0, oversample_factor_o);
		chk("span_sel", 16'h5555, span_sel_o);
		// Serial port: writes refused until a read frame
		hreset(5'h1E);
		chk("sdo_oe idle", 1'b0, sdo_oe_o);
		spi({1'b0, 7'h08, 8'h08});
		chk("factor", 4'h0, oversample_factor_o);
		spi({1'b1, 7'h0A, 8'h00});
		spi({1'b1, 7'h01, 8'h00});
		chk("spi read", 16'h0051, rx);
		spi({1'b0, 7'h08, 8'h08});
		chk("spi status", 16'h0001, rx);
		chk("factor", 4'h8, oversample_factor_o);
		spi({1'b0, 7'h08, 8'h09});
		chk("factor clamp", 4'h8, oversample_factor_o);
		spi({1'b0, 7'h02, 8'h02});
		chk("dout_lines", 2'h2, dout_lines_o);
		spi({1'b0, 7'h02, 8'h00});
		chk("dout_lines", 2'h0, dout_lines_o);
		hreset(5'h1E);
		chk("factor", 4'h0, oversample_factor_o);
		chk("dout_lines", 2'h1, dout_lines_o);
		spi({1'b0, 7'h08, 8'h08});
		chk("factor", 4'h0, oversample_factor_o);
		// Host reset event alone raises the line
		wb(1'b1, 8'h11, 32'h0000_0002);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk("irq idle", 1'b0, irq_o);
		hreset(5'h1E);
		chk("irq reset event", 1'b1, irq_o);
		tally_and_finish();
	end

	// ===========================================================
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		$display("mismatch watchdog expected done seen hang");
		tally_and_finish();
	end
endmodule
